// ### spread_nvm_pkg.sv
// Package: shared constants and types for the spread and nonvolatile
// program control link, device end and host end.
// Assumes one 200 MHz clock shared by both ends.
package spread_nvm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Device register map
  localparam int NUM_BYTES = 27;
  localparam logic [7:0] OFS_LOOP_CTRL = 8'h03;
  localparam logic [7:0] OFS_BUSY = 8'h18;
  localparam logic [7:0] OFS_SPREAD = 8'h19;
  localparam logic [7:0] OFS_RDLEN = 8'h1a;
  localparam int LOOP_BYPASS_BIT = 6;
  localparam int BUSY_BIT = 7;
  localparam int RATE_LSB = 0;
  localparam int SPREAD_LSB = 4;
  localparam int LOCK_BIT = 7;
  localparam int TRIG_BIT = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [6:0] RDLEN_DEFAULT = 7'h1b;

  // Spread amount codes, ascending
  localparam logic [2:0] SPREAD_BYPASS = 3'h0;
  localparam logic [2:0] SPREAD_CENTER_0P10 = 3'h1;
  localparam logic [2:0] SPREAD_CENTER_0P25 = 3'h2;
  localparam logic [2:0] SPREAD_CENTER_0P40 = 3'h3;
  localparam logic [2:0] SPREAD_DOWN_1P0 = 3'h4;
  localparam logic [2:0] SPREAD_DOWN_1P5 = 3'h5;
  localparam logic [2:0] SPREAD_DOWN_2P0 = 3'h6;
  localparam logic [2:0] SPREAD_DOWN_3P0 = 3'h7;

  // Timing: one byte of nonvolatile write
  localparam int CLK_PERIOD_PS = 5000;
  localparam int NVM_BYTE_WR_NS = 100;
  localparam int NVM_BYTE_WR_CYC = (NVM_BYTE_WR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  ////////////////////////////////////////////////////////////////////////////
  // Host software registers
  localparam logic [7:0] HOFS_CTRL = 8'h00;
  localparam logic [7:0] HOFS_ADDR = 8'h01;
  localparam logic [7:0] HOFS_WDATA = 8'h02;
  localparam logic [7:0] HOFS_STATUS = 8'h03;
  localparam logic [7:0] HOFS_RDATA = 8'h04;
  localparam logic [7:0] HOFS_IRQ_STAT = 8'h05;
  localparam logic [7:0] HOFS_IRQ_MASK = 8'h06;
  localparam logic [7:0] HOFS_BLK_CNT = 8'h07;
  localparam int HOFS_BLK_BIT = 7;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_REFUSED_BIT = 1;

  // Host operation codes
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_BLOCK = 3'h3;
  localparam logic [2:0] OP_SPREAD = 3'h4;
  localparam logic [2:0] OP_PROGRAM = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // State encodings
  typedef enum logic [2:0] {
    D_LOAD = 3'h1,
    D_IDLE = 3'h2,
    D_PROG = 3'h4
  } dev_state_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_SEND = 3'h2,
    H_WAIT = 3'h4
  } host_state_e;

endpackage : spread_nvm_pkg

// ### cfg_link_if.sv
// Interface: byte-wide register link between host and device.
// Assumes both ends sample it on the same rising clock edge.
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
  logic wr;
  logic rd;
  logic blk;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  logic rlast;
  logic ready;

  modport dev (input wr, rd, blk, addr, wdata, output rdata, rvalid, rlast, ready);
  modport host (output wr, rd, blk, addr, wdata, input rdata, rvalid, rlast, ready);
endinterface : cfg_link_if
`default_nettype wire

// ### spread_nvm_dev.sv
// Device end: configuration bytes, spread decode, nonvolatile lock,
// block readback length and the edge-triggered nonvolatile write cycle.
// Assumes an external nonvolatile array with combinational read data.
//
// Function
// - Spread code: bypass, three center, four down
// - Bypass code powers down spread, output low
// - Host bypasses loop around spread amount change
// - Host bypasses loop around rate factor change
// - Lock bit set blocks programming until the next reset
// - Locked: register writes still apply, not stored
// - Readback length 1 to 127, default 27; here cleared at reset, then loaded from the array
// - Programming starts only on trigger rising edge
// - Trigger bit keeps host value after programming
// - Host writes zero then one to trigger
// - Host sends no writes while programming
// - Byte and block reads served while programming
// - Busy flag readable at byte 24 bit 7
// - Trigger edge ignored while lock is set
// - Busy high during programming, writes ignored
`timescale 1ns/1ps
`default_nettype none
module spread_nvm_dev #(
  parameter int BYTE_WR_CYC = spread_nvm_pkg::NVM_BYTE_WR_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Link to host
  cfg_link_if.dev lk,
  // Nonvolatile array
  output logic nvm_we_o,
  output logic [4:0] nvm_addr_o,
  output logic [7:0] nvm_wdata_o,
  input wire logic [7:0] nvm_rdata_i,
  // Spreading loop controls
  output logic [2:0] spread_amount_o,
  output logic [3:0] spread_rate_sel_o,
  output logic spread_power_down_o,
  output logic spread_hold_low_o,
  output logic loop_bypass_o,
  // Status
  output logic [6:0] readback_len_o,
  output logic nvm_permanent_lock_o,
  output logic nvm_busy_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef logic [spread_nvm_pkg::NUM_BYTES-1:0][7:0] cfg_t;

  typedef struct packed {
    spread_nvm_pkg::dev_state_e st;
    cfg_t cfg;
    logic lock;
    logic [4:0] nvm_addr;
    logic nvm_we;
    logic [7:0] nvm_wdata;
    logic [4:0] pidx;
    logic [15:0] tmr;
    logic [6:0] sidx;
    logic [6:0] sleft;
    logic [7:0] rdata;
    logic rvalid;
    logic rlast;
  } dev_s;

  localparam logic [4:0] LAST_IDX = 5'(spread_nvm_pkg::NUM_BYTES - 1);
  localparam logic [4:0] END_IDX = 5'(spread_nvm_pkg::NUM_BYTES);
  localparam logic [15:0] WAIT_CYC = 16'(BYTE_WR_CYC - 1);

  dev_s q_r;
  dev_s q_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Byte seen by a read; busy flag overlays byte 24 bit 7
  function automatic logic [7:0] reg_byte(input cfg_t c, input logic [7:0] a,
                                          input logic busy);
    logic [7:0] v;
    v = 8'h00;
    if (a < 8'(spread_nvm_pkg::NUM_BYTES)) begin
      v = c[a[4:0]];
    end
    if (a == spread_nvm_pkg::OFS_BUSY) begin
      v[spread_nvm_pkg::BUSY_BIT] = busy;
    end
    return v;
  endfunction : reg_byte

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic busy;
    logic [7:0] wv;
    logic [6:0] cnt;
    busy = 1'b0;
    wv = 8'h00;
    cnt = 7'h00;
    q_nxt = q_r;
    q_nxt.nvm_we = 1'b0;
    q_nxt.rvalid = 1'b0;
    q_nxt.rlast = 1'b0;
    busy = (q_r.st == spread_nvm_pkg::D_PROG);

    // Read service, also while programming
    if (q_r.st != spread_nvm_pkg::D_LOAD) begin
      if (q_r.sleft != 7'h00) begin
        q_nxt.rdata = reg_byte(q_r.cfg, {1'b0, q_r.sidx}, busy);
        q_nxt.rvalid = 1'b1;
        q_nxt.rlast = (q_r.sleft == 7'h01);
        q_nxt.sidx = q_r.sidx + 7'h01;
        q_nxt.sleft = q_r.sleft - 7'h01;
      end else if (lk.blk) begin
        cnt = q_r.cfg[spread_nvm_pkg::OFS_RDLEN[4:0]][6:0];
        if (cnt == 7'h00) begin
          cnt = 7'h01;
        end
        q_nxt.rdata = reg_byte(q_r.cfg, 8'h00, busy);
        q_nxt.rvalid = 1'b1;
        q_nxt.rlast = (cnt == 7'h01);
        q_nxt.sidx = 7'h01;
        q_nxt.sleft = cnt - 7'h01;
      end else if (lk.rd) begin
        q_nxt.rdata = reg_byte(q_r.cfg, lk.addr, busy);
        q_nxt.rvalid = 1'b1;
        q_nxt.rlast = 1'b1;
      end
    end

    case (q_r.st)
      // Power-up copy of the nonvolatile array into the registers
      spread_nvm_pkg::D_LOAD: begin
        q_nxt.cfg[q_r.nvm_addr] = nvm_rdata_i;
        if (q_r.nvm_addr == spread_nvm_pkg::OFS_SPREAD[4:0] &&
            nvm_rdata_i[spread_nvm_pkg::LOCK_BIT]) begin
          q_nxt.lock = 1'b1;
        end
        if (q_r.nvm_addr == LAST_IDX) begin
          q_nxt.st = spread_nvm_pkg::D_IDLE;
          q_nxt.nvm_addr = 5'h00;
        end else begin
          q_nxt.nvm_addr = q_r.nvm_addr + 5'h01;
        end
      end

      // Register writes take effect at once, locked or not
      spread_nvm_pkg::D_IDLE: begin
        if (lk.wr && lk.addr < 8'(spread_nvm_pkg::NUM_BYTES)) begin
          wv = lk.wdata;
          if (lk.addr == spread_nvm_pkg::OFS_BUSY) begin
            wv[spread_nvm_pkg::BUSY_BIT] = 1'b0;
          end
          q_nxt.cfg[lk.addr[4:0]] = wv;
          if (lk.addr == spread_nvm_pkg::OFS_SPREAD && wv[spread_nvm_pkg::LOCK_BIT]) begin
            q_nxt.lock = 1'b1;
          end
          // Rising edge of the trigger bit, refused under lock
          if (lk.addr == spread_nvm_pkg::OFS_RDLEN && wv[spread_nvm_pkg::TRIG_BIT] &&
              !q_r.cfg[spread_nvm_pkg::OFS_RDLEN[4:0]][spread_nvm_pkg::TRIG_BIT] &&
              !q_r.lock) begin
            q_nxt.st = spread_nvm_pkg::D_PROG;
            q_nxt.pidx = 5'h00;
            q_nxt.tmr = 16'h0000;
          end
        end
      end

      // One byte per write time; link writes are ignored here
      spread_nvm_pkg::D_PROG: begin
        if (q_r.tmr != 16'h0000) begin
          q_nxt.tmr = q_r.tmr - 16'h0001;
        end else if (q_r.pidx == END_IDX) begin
          q_nxt.st = spread_nvm_pkg::D_IDLE;
        end else begin
          q_nxt.nvm_we = 1'b1;
          q_nxt.nvm_addr = q_r.pidx;
          q_nxt.nvm_wdata = q_r.cfg[q_r.pidx];
          q_nxt.pidx = q_r.pidx + 5'h01;
          q_nxt.tmr = WAIT_CYC;
        end
      end

      default: begin
        q_nxt.st = spread_nvm_pkg::D_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; registers start cleared and load from the array
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_r.st <= spread_nvm_pkg::D_LOAD;
      q_r.cfg <= {spread_nvm_pkg::NUM_BYTES{spread_nvm_pkg::CFG_RESET}};
      q_r.lock <= 1'b0;
      q_r.nvm_addr <= 5'h00;
      q_r.nvm_we <= 1'b0;
      q_r.nvm_wdata <= 8'h00;
      q_r.pidx <= 5'h00;
      q_r.tmr <= 16'h0000;
      q_r.sidx <= 7'h00;
      q_r.sleft <= 7'h00;
      q_r.rdata <= 8'h00;
      q_r.rvalid <= 1'b0;
      q_r.rlast <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link answers
  assign lk.rdata = q_r.rdata;
  assign lk.rvalid = q_r.rvalid;
  assign lk.rlast = q_r.rlast;
  assign lk.ready = (q_r.st != spread_nvm_pkg::D_LOAD);

  // Nonvolatile array port
  assign nvm_we_o = q_r.nvm_we;
  assign nvm_addr_o = q_r.nvm_addr;
  assign nvm_wdata_o = q_r.nvm_wdata;

  // Spreading loop controls decoded from the registers
  assign spread_amount_o =
    q_r.cfg[spread_nvm_pkg::OFS_SPREAD[4:0]][spread_nvm_pkg::SPREAD_LSB +: 3];
  assign spread_rate_sel_o =
    q_r.cfg[spread_nvm_pkg::OFS_SPREAD[4:0]][spread_nvm_pkg::RATE_LSB +: 4];
  assign spread_power_down_o = (spread_amount_o == spread_nvm_pkg::SPREAD_BYPASS);
  assign spread_hold_low_o = (spread_amount_o == spread_nvm_pkg::SPREAD_BYPASS);
  assign loop_bypass_o =
    q_r.cfg[spread_nvm_pkg::OFS_LOOP_CTRL[4:0]][spread_nvm_pkg::LOOP_BYPASS_BIT];

  // Status
  assign readback_len_o = q_r.cfg[spread_nvm_pkg::OFS_RDLEN[4:0]][6:0];
  assign nvm_permanent_lock_o = q_r.lock;
  assign nvm_busy_flag_o = (q_r.st == spread_nvm_pkg::D_PROG);

endmodule : spread_nvm_dev
`default_nettype wire

// ### spread_nvm_host.sv
// Host end: software command registers driving the link, with safe
// spread update and program sequences and a block read buffer.
// Assumes the device end of cfg_link_if on the same clock.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
module spread_nvm_host (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Software port
  input wire logic [7:0] sw_addr_i,
  input wire logic [7:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [7:0] sw_rdata_o,
  // Interrupt
  output logic irq_o,
  // Link to device
  cfg_link_if.host lk
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    spread_nvm_pkg::host_state_e st;
    logic [2:0] op;
    logic [1:0] step;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] shadow;
    logic [7:0] rdata;
    logic [7:0] blk_cnt;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic lk_wr;
    logic lk_rd;
    logic lk_blk;
    logic [7:0] lk_addr;
    logic [7:0] lk_wdata;
    logic [7:0] sw_rdata;
  } host_s;

  host_s q_r;
  host_s q_nxt;
  logic [7:0] blk_mem [0:127];

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [1:0] set;
    logic [1:0] clr;
    logic done;
    set = 2'b00;
    clr = 2'b00;
    done = 1'b0;
    q_nxt = q_r;
    q_nxt.lk_wr = 1'b0;
    q_nxt.lk_rd = 1'b0;
    q_nxt.lk_blk = 1'b0;

    case (q_r.st)
      spread_nvm_pkg::H_IDLE: begin
        if (sw_wr_i && sw_addr_i == spread_nvm_pkg::HOFS_CTRL) begin
          if (!lk.ready || sw_wdata_i[2:0] == 3'h0 || sw_wdata_i[2:0] > 3'h5 ||
              ((sw_wdata_i[2:0] == spread_nvm_pkg::OP_PROGRAM ||
                (sw_wdata_i[2:0] == spread_nvm_pkg::OP_WRITE &&
                 q_r.addr == spread_nvm_pkg::OFS_RDLEN)) &&
               q_r.wdata[6:0] == 7'h00)) begin
            set[spread_nvm_pkg::IRQ_REFUSED_BIT] = 1'b1;
          end else begin
            q_nxt.op = sw_wdata_i[2:0];
            q_nxt.step = 2'h0;
            q_nxt.st = spread_nvm_pkg::H_SEND;
            q_nxt.blk_cnt = 8'h00;
          end
        end
      end

      // One link command per cycle, chosen by operation and step
      spread_nvm_pkg::H_SEND: begin
        q_nxt.step = q_r.step + 2'h1;
        case (q_r.op)
          spread_nvm_pkg::OP_WRITE: begin
            q_nxt.lk_wr = 1'b1;
            q_nxt.lk_addr = q_r.addr;
            q_nxt.lk_wdata = q_r.wdata;
            done = 1'b1;
          end
          spread_nvm_pkg::OP_READ: begin
            q_nxt.lk_rd = 1'b1;
            q_nxt.lk_addr = q_r.addr;
            q_nxt.st = spread_nvm_pkg::H_WAIT;
          end
          spread_nvm_pkg::OP_BLOCK: begin
            q_nxt.lk_blk = 1'b1;
            q_nxt.st = spread_nvm_pkg::H_WAIT;
          end
          // Loop bypass around the spread byte write
          spread_nvm_pkg::OP_SPREAD: begin
            q_nxt.lk_addr = spread_nvm_pkg::OFS_LOOP_CTRL;
            if (q_r.step == 2'h0) begin
              q_nxt.lk_rd = 1'b1;
              q_nxt.st = spread_nvm_pkg::H_WAIT;
            end else if (q_r.step == 2'h1) begin
              q_nxt.lk_wr = 1'b1;
              q_nxt.lk_wdata = q_r.shadow | (8'h01 << spread_nvm_pkg::LOOP_BYPASS_BIT);
            end else if (q_r.step == 2'h2) begin
              q_nxt.lk_wr = 1'b1;
              q_nxt.lk_addr = spread_nvm_pkg::OFS_SPREAD;
              q_nxt.lk_wdata = q_r.wdata;
            end else begin
              q_nxt.lk_wr = 1'b1;
              q_nxt.lk_wdata = q_r.shadow & ~(8'h01 << spread_nvm_pkg::LOOP_BYPASS_BIT);
              done = 1'b1;
            end
          end
          // Trigger low then high, then poll busy with reads only
          default: begin
            if (q_r.step == 2'h2) begin
              q_nxt.lk_rd = 1'b1;
              q_nxt.lk_addr = spread_nvm_pkg::OFS_BUSY;
              q_nxt.step = q_r.step;
              q_nxt.st = spread_nvm_pkg::H_WAIT;
            end else begin
              q_nxt.lk_wr = 1'b1;
              q_nxt.lk_addr = spread_nvm_pkg::OFS_RDLEN;
              q_nxt.lk_wdata = {q_r.step[0], q_r.wdata[6:0]};
            end
          end
        endcase
      end

      // Collect read answers
      spread_nvm_pkg::H_WAIT: begin
        if (lk.rvalid) begin
          q_nxt.rdata = lk.rdata;
          q_nxt.blk_cnt = q_r.blk_cnt + 8'h01;
          if (lk.rlast) begin
            if (q_r.op == spread_nvm_pkg::OP_SPREAD) begin
              q_nxt.shadow = lk.rdata;
              q_nxt.st = spread_nvm_pkg::H_SEND;
            end else if (q_r.op == spread_nvm_pkg::OP_PROGRAM &&
                         lk.rdata[spread_nvm_pkg::BUSY_BIT]) begin
              q_nxt.st = spread_nvm_pkg::H_SEND;
            end else begin
              done = 1'b1;
            end
          end
        end
      end

      default: begin
        q_nxt.st = spread_nvm_pkg::H_IDLE;
      end
    endcase

    if (done) begin
      q_nxt.st = spread_nvm_pkg::H_IDLE;
      set[spread_nvm_pkg::IRQ_DONE_BIT] = 1'b1;
    end

    // Software writes to plain registers
    if (sw_wr_i) begin
      if (sw_addr_i == spread_nvm_pkg::HOFS_ADDR) begin
        q_nxt.addr = sw_wdata_i;
      end else if (sw_addr_i == spread_nvm_pkg::HOFS_WDATA) begin
        q_nxt.wdata = sw_wdata_i;
      end else if (sw_addr_i == spread_nvm_pkg::HOFS_IRQ_STAT) begin
        clr = sw_wdata_i[1:0];
      end else if (sw_addr_i == spread_nvm_pkg::HOFS_IRQ_MASK) begin
        q_nxt.irq_mask = sw_wdata_i[1:0];
      end
    end
    // Set wins over write-one clear
    q_nxt.irq_stat = (q_r.irq_stat & ~clr) | set;

    // Read data, valid the cycle after the read strobe
    q_nxt.sw_rdata = 8'h00;
    if (sw_rd_i) begin
      if (sw_addr_i[spread_nvm_pkg::HOFS_BLK_BIT]) begin
        q_nxt.sw_rdata = blk_mem[sw_addr_i[6:0]];
      end else if (sw_addr_i == spread_nvm_pkg::HOFS_ADDR) begin
        q_nxt.sw_rdata = q_r.addr;
      end else if (sw_addr_i == spread_nvm_pkg::HOFS_WDATA) begin
        q_nxt.sw_rdata = q_r.wdata;
      end else if (sw_addr_i == spread_nvm_pkg::HOFS_STATUS) begin
        q_nxt.sw_rdata = {6'h00, lk.ready, q_r.st != spread_nvm_pkg::H_IDLE};
      end else if (sw_addr_i == spread_nvm_pkg::HOFS_RDATA) begin
        q_nxt.sw_rdata = q_r.rdata;
      end else if (sw_addr_i == spread_nvm_pkg::HOFS_IRQ_STAT) begin
        q_nxt.sw_rdata = {6'h00, q_r.irq_stat};
      end else if (sw_addr_i == spread_nvm_pkg::HOFS_IRQ_MASK) begin
        q_nxt.sw_rdata = {6'h00, q_r.irq_mask};
      end else if (sw_addr_i == spread_nvm_pkg::HOFS_BLK_CNT) begin
        q_nxt.sw_rdata = q_r.blk_cnt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_r <= '{st: spread_nvm_pkg::H_IDLE, default: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  // Block read buffer, indexed by arrival order
  always_ff @(posedge sys_clk_i) begin
    if (q_r.st == spread_nvm_pkg::H_WAIT && lk.rvalid) begin
      blk_mem[q_r.blk_cnt[6:0]] <= lk.rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign lk.wr = q_r.lk_wr;
  assign lk.rd = q_r.lk_rd;
  assign lk.blk = q_r.lk_blk;
  assign lk.addr = q_r.lk_addr;
  assign lk.wdata = q_r.lk_wdata;
  assign sw_rdata_o = q_r.sw_rdata;
  assign irq_o = |(q_r.irq_stat & q_r.irq_mask);

endmodule : spread_nvm_host
`default_nettype wire

// ### spread_nvm_dev_files_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### spread_nvm_sva.sv
// Checker: link relations between the host end and the device end.
// Assumes it is instantiated beside the interface, on the shared clock.
`timescale 1ns/1ps
`default_nettype none
module spread_nvm_sva (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Link signals
  input wire logic wr,
  input wire logic rd,
  input wire logic blk,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic rlast,
  input wire logic ready
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  logic byp_r;
  ////////////////////////////////////////////////////////////////////////////
  // Last loop bypass value written to the device
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      byp_r <= 1'b0;
    end else if (wr && addr == spread_nvm_pkg::OFS_LOOP_CTRL) begin
      byp_r <= wdata[spread_nvm_pkg::LOOP_BYPASS_BIT];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Answers and readiness
  property p_rd_answer; (rd && ready) |=> (rvalid && rlast); endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("byte read not answered next cycle");
  property p_blk_answer; (blk && ready) |=> rvalid; endproperty
  a_blk_answer: assert property (p_blk_answer)
    else $error("block read not answered next cycle");
  property p_rlast_valid; rlast |-> rvalid; endproperty
  a_rlast_valid: assert property (p_rlast_valid)
    else $error("last flag without data");
  property p_ready_hold; ready |=> ready; endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("ready dropped");
  property p_ready_load; $rose(resetn_i) |-> !ready [*8]; endproperty
  a_ready_load: assert property (p_ready_load)
    else $error("ready before power-up load");
  property p_rvalid_cause; $rose(rvalid) |-> ($past(rd) || $past(blk)); endproperty
  a_rvalid_cause: assert property (p_rvalid_cause)
    else $error("read data without request");
  // Safe spread change: bypass before, re-enable after
  sequence s_reenable;
    ##[1:20] (wr && addr == spread_nvm_pkg::OFS_LOOP_CTRL &&
              !wdata[spread_nvm_pkg::LOOP_BYPASS_BIT]);
  endsequence
  property p_bypass_first; (wr && addr == spread_nvm_pkg::OFS_SPREAD) |-> byp_r; endproperty
  a_bypass_first: assert property (p_bypass_first)
    else $error("spread byte written with loop active");
  property p_reenable; (wr && addr == spread_nvm_pkg::OFS_SPREAD) |-> s_reenable; endproperty
  a_reenable: assert property (p_reenable)
    else $error("loop not re-enabled after spread write");
endmodule : spread_nvm_sva
`default_nettype wire

// ### spread_and_eeprom_program_control_test.sv
// Testbench: host end and device end joined, driven from the software port.
// Assumes a small array model behind the device and a short byte write time.
`timescale 1ns/1ps
`default_nettype none
module spread_and_eeprom_program_control_test;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] sw_addr = 8'h00, sw_wdata = 8'h00, sw_rdata, nvm_wdata, d;
  logic sw_wr = 1'b0, sw_rd = 1'b0, irq, nvm_we, pdn, hlow, byp, lock, busy;
  logic [4:0] nvm_addr;
  logic [2:0] amt;
  logic [3:0] rate;
  logic [6:0] rlen;
  logic [7:0] mem [0:31];
  wire logic [7:0] nvm_rdata = mem[nvm_addr];
  int bad_count = 0, compares = 0, wecnt = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Clock, timeout and array model
  always #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc++;
    if (nvm_we === 1'b1) begin
      mem[nvm_addr] <= nvm_wdata;
      wecnt++;
    end
    if (cyc == 30000) begin
      bad_count++;
      test_done();
    end
  end
  cfg_link_if lk();
  spread_nvm_dev #(.BYTE_WR_CYC(2)) i_spread_nvm_dev (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .lk(lk), .nvm_we_o(nvm_we), .nvm_addr_o(nvm_addr),
    .nvm_wdata_o(nvm_wdata), .nvm_rdata_i(nvm_rdata), .spread_amount_o(amt),
    .spread_rate_sel_o(rate), .spread_power_down_o(pdn), .spread_hold_low_o(hlow),
    .loop_bypass_o(byp), .readback_len_o(rlen), .nvm_permanent_lock_o(lock),
    .nvm_busy_flag_o(busy));
  spread_nvm_host i_spread_nvm_host (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd),
    .sw_rdata_o(sw_rdata), .irq_o(irq), .lk(lk));
  spread_nvm_sva i_spread_nvm_sva (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .wr(lk.wr), .rd(lk.rd), .blk(lk.blk), .addr(lk.addr), .wdata(lk.wdata),
    .rdata(lk.rdata), .rvalid(lk.rvalid), .rlast(lk.rlast), .ready(lk.ready));
  ////////////////////////////////////////////////////////////////////////////
  // Software port tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic sw_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge sys_clk_i);
    sw_wr <= 1'b0;
  endtask : sw_write
  task automatic sw_read(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk_i);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk_i);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
  endtask : sw_read
  task automatic op_start(input logic [2:0] code, input logic [7:0] a, input logic [7:0] v);
    sw_write(spread_nvm_pkg::HOFS_ADDR, a);
    sw_write(spread_nvm_pkg::HOFS_WDATA, v);
    sw_write(spread_nvm_pkg::HOFS_CTRL, {5'h00, code});
  endtask : op_start
  task automatic op_wait();
    logic [7:0] s;
    for (int i = 0; i < 300; i++) begin
      sw_read(spread_nvm_pkg::HOFS_STATUS, s);
      if (s[0] === 1'b0) break;
    end
    check(s & 8'h01, 8'h00);
  endtask : op_wait
  task automatic op(input logic [2:0] code, input logic [7:0] a, input logic [7:0] v);
    op_start(code, a, v);
    op_wait();
  endtask : op
  task automatic dev_read(input logic [7:0] a, output logic [7:0] v);
    op(spread_nvm_pkg::OP_READ, a, 8'h00);
    sw_read(spread_nvm_pkg::HOFS_RDATA, v);
  endtask : dev_read
  // Verdict and end of run
  task automatic test_done();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    for (int i = 0; i < 32; i++) mem[i] = 8'(i);
    mem[26] = 8'h03;
    repeat (10) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (40) @(posedge sys_clk_i);
    sw_read(spread_nvm_pkg::HOFS_STATUS, d);
    check(d & 8'h02, 8'h02);
    dev_read(spread_nvm_pkg::OFS_RDLEN, d);
    check(d, 8'h03);
    check(8'(rlen), 8'h03);
    op(spread_nvm_pkg::OP_BLOCK, 8'h00, 8'h00);
    sw_read(spread_nvm_pkg::HOFS_BLK_CNT, d);
    check(d, 8'h03);
    sw_read(8'h82, d);
    check(d, 8'h02);
    $display("load and block test done");
    for (int c = 0; c < 8; c++) begin
      op(spread_nvm_pkg::OP_SPREAD, 8'h00, {1'b0, 3'(c), 4'h9});
      check(8'(amt), 8'(c));
      check(8'({pdn, hlow}), (c == 0) ? 8'h03 : 8'h00);
      check(8'({rate, byp}), 8'h12);
    end
    $display("spread test done");
    wecnt = 0;
    op_start(spread_nvm_pkg::OP_PROGRAM, 8'h00, 8'h05);
    repeat (12) @(posedge sys_clk_i);
    check(8'(busy), 8'h01);
    op_wait();
    check(8'(wecnt), 8'd27);
    check(mem[26], 8'h85);
    check(mem[25], 8'h79);
    dev_read(spread_nvm_pkg::OFS_RDLEN, d);
    check(d, 8'h85);
    op(spread_nvm_pkg::OP_WRITE, spread_nvm_pkg::OFS_RDLEN, 8'h85);
    repeat (10) @(posedge sys_clk_i);
    check(8'(wecnt), 8'd27);
    op(spread_nvm_pkg::OP_WRITE, spread_nvm_pkg::OFS_BUSY, 8'h80);
    dev_read(spread_nvm_pkg::OFS_BUSY, d);
    check(d, 8'h00);
    $display("program test done");
    op(spread_nvm_pkg::OP_SPREAD, 8'h00, 8'hf3);
    op(spread_nvm_pkg::OP_SPREAD, 8'h00, 8'h25);
    check(8'({lock, amt}), 8'h0a);
    wecnt = 0;
    op(spread_nvm_pkg::OP_PROGRAM, 8'h00, 8'h06);
    repeat (10) @(posedge sys_clk_i);
    check(8'(wecnt), 8'd0);
    check(mem[25], 8'h79);
    $display("lock test done");
    sw_write(spread_nvm_pkg::HOFS_IRQ_STAT, 8'h03);
    sw_write(spread_nvm_pkg::HOFS_IRQ_MASK, 8'h02);
    op(spread_nvm_pkg::OP_PROGRAM, 8'h00, 8'h00);
    check(8'(irq), 8'h01);
    sw_read(spread_nvm_pkg::HOFS_IRQ_STAT, d);
    check(d, 8'h02);
    sw_write(spread_nvm_pkg::HOFS_IRQ_STAT, 8'h02);
    #1 check(8'(irq), 8'h00);
    sw_read(8'h10, d);
    check(d, 8'h00);
    $display("interrupt test done");
    // Second power-up: stored bytes come back, lock was never stored
    resetn_i <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (40) @(posedge sys_clk_i);
    check(8'({lock, amt, rate}), 8'h79);
    check(8'(rlen), 8'h05);
    $display("reload test done");
    test_done();
  end
endmodule : spread_and_eeprom_program_control_test
`default_nettype wire
